// ==== rtl/cpm_pkg.sv ====
// Constants and types for the clock and power management block
package cpm_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int WAKE_OSC_CYC = 992;
	localparam int WAKE_EXTRA_US = 60;
	localparam int WAKE_EXTRA_CYC = (WAKE_EXTRA_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam logic [11:0] WAKE_LOAD = 12'(WAKE_OSC_CYC + WAKE_EXTRA_CYC - 1);
	localparam logic [11:0] WAKE_SHORT = 12'h000;
	localparam logic [7:0] DIV_RST = 8'h00;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] A_CLKDIV = 8'h00;
	localparam logic [7:0] A_AUX1 = 8'h04;
	localparam logic [7:0] A_PWR = 8'h08;
	localparam logic [7:0] A_RCAUSE = 8'h0c;
	localparam logic [7:0] A_P0M1 = 8'h10;
	localparam logic [7:0] A_P0M2 = 8'h14;
	localparam logic [7:0] A_P1M1 = 8'h18;
	localparam logic [7:0] A_P1M2 = 8'h1c;
	localparam logic [7:0] A_P3M1 = 8'h20;
	localparam logic [7:0] A_P3M2 = 8'h24;
	localparam logic [7:0] A_IPLO = 8'h28;
	localparam logic [7:0] A_IPHI = 8'h2c;
	localparam logic [7:0] A_STAT = 8'h30;
	localparam logic [7:0] A_NONE = 8'hfc;
	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int AUX_LPSEL = 7;
	localparam int PWR_BOI = 4;
	localparam int PWR_BOE = 5;
	localparam int PWR_RTCEN = 7;
	localparam int PWR_CMPPD = 8;
	localparam int PWR_SWRST = 9;
	localparam int RC_EXT = 0;
	localparam int RC_BOF = 5;
	localparam logic [5:0] RCAUSE_RST = 6'h30;
	localparam logic [7:0] PM1_RST = 8'hff;
	localparam logic [7:0] PM2_RST = 8'h00;
	localparam logic [7:0] SHR_MASK = 8'h20;
	localparam logic [2:0] PINS_MAX = 3'h6;
	localparam logic [7:0] RAM_TOP = 8'h80;
	localparam int RAM_BYTES = 128;
	localparam logic [15:0] CODE_TOP = 16'h0400;
	localparam int IRQ_SRCS = 8;

	typedef enum logic [3:0] {
		ST_WAKE = 4'b0001,
		ST_RUN = 4'b0010,
		ST_IDLE = 4'b0100,
		ST_PD = 4'b1000
	} cpm_state_t;
	typedef enum logic [1:0] {MD_RUN, MD_IDLE, MD_PD, MD_TPD} cpm_mode_t;
	typedef enum logic [1:0] {CS_RC, CS_WDOSC, CS_EXT, CS_XTAL} cpm_clksrc_t;
	typedef struct packed {
		logic [7:0] m1;
		logic [7:0] m2;
	} cpm_pcfg_t;
endpackage

// ==== rtl/cpm_top.sv ====
// Clock and power management block with AHB-Lite register slave
// Behaviour
// - Crystal wake delay: 992 cycles plus 60 us
// - CPU clock from divider, ratio up to 510
// - Divider rewritable anytime without stalling core
// - Every reset clears low-power select
// - 128-byte data RAM, direct and indirect
// - Special registers reachable by direct access only
// - 64 kB code space, 1 kB on chip
// - Four-level interrupt priority arbitration
// - Per-pin mode from two config registers
// - Shared reset pin is always input-only
// - All pins input-only after power-up
// - Usable pins depend on clock, reset option
// - Brownout resets, or raises interrupt if configured
// - Power-on flag stays until firmware clears it
// - Idle keeps peripherals; interrupt or reset resumes
// - Power-down stops oscillator; reset or interrupt exits
// - Brownout, comparators stay alive in power-down
// - RC oscillator off in power-down unless needed
// - Total power-down also kills brownout, comparators
// - Power-on sets both power flags, clears others
// - Writing zero clears a cause flag
`timescale 1ns/1ns
`default_nettype none
module cpm_top
	import cpm_pkg::*;
(
	input wire logic REF_CLK, // 50 MHz clock
	input wire logic RSTN, // Power-on reset
	input wire logic CE, // Clock enable
	input wire logic HSEL, // Slave select
	input wire logic [31:0] HADDR, // Byte address
	input wire logic [1:0] HTRANS, // Transfer type
	input wire logic HWRITE, // Write access
	input wire logic [2:0] HSIZE, // Word only
	input wire logic [31:0] HWDATA, // Write data
	input wire logic HREADY, // Bus ready
	output logic HREADYOUT, // Slave ready
	output logic [31:0] HRDATA, // Read data
	output logic HRESP, // Always OKAY
	input wire cpm_clksrc_t CLK_SRC, // Clock source strap
	input wire logic RST_PIN_EN, // External reset option
	input wire logic EXT_RST_REQ, // Pin reset pulse
	input wire logic WDT_RST_REQ, // Watchdog reset pulse
	input wire logic BRK_RST_REQ, // Break reset pulse
	input wire logic BO_DET, // Supply below trip level
	input wire logic IRQ_WAKE, // Enabled irq pending
	input wire logic PD_WAKE, // Power-down wake irq
	input wire logic [7:0] IRQ_REQ, // Interrupt requests
	input wire logic [7:0] DM_ADDR, // Data address
	input wire logic DM_IND, // Indirect access
	input wire logic DM_WR, // Data write
	input wire logic [7:0] DM_WDATA, // Data to write
	output logic [7:0] DM_RDATA, // Data read
	output logic SFR_SEL, // Special register hit
	input wire logic [15:0] CODE_ADDR, // Code address
	output logic CODE_ONCHIP, // Code on chip
	output logic CPU_TICK, // CPU clock enable
	output logic CORE_RST, // Core held in reset
	output logic PERIPH_RUN, // Peripherals clocked
	output logic OSC_ON, // Main oscillator on
	output logic RC_OSC_ON, // RC oscillator on
	output logic BOD_ON, // Brownout detector on
	output logic CMP_ON, // Comparators on
	output logic BO_IRQ, // Brownout interrupt
	output logic LP_SEL, // Low-power clock select
	output cpm_pcfg_t PORT0_CFG, // Port 0 modes
	output cpm_pcfg_t PORT1_CFG, // Port 1 modes
	output cpm_pcfg_t PORT3_CFG, // Port 3 modes
	output logic IRQ_VALID, // Winner present
	output logic [2:0] IRQ_ID, // Winning source
	output logic [1:0] IRQ_LEVEL, // Winning level
	output logic [2:0] USABLE_PINS // Usable pin count
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] clkdiv;
	logic lpsel;
	cpm_mode_t mode;
	logic boi, brownout_enable_cfg, rtc_en, cmp_pd;
	logic [5:0] rcause;
	cpm_pcfg_t p0, p1, p3;
	logic [7:0] ip_lo, ip_hi;
	cpm_state_t state, next_state;
	logic [11:0] wake_cnt, next_wake_cnt;
	logic wake_rst;
	logic [8:0] div_cnt;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] rd_mux;
	logic [1:0] lvl, arb_lvl;
	logic arb_ok;
	logic [2:0] arb_id;
	logic [7:0] dram [0:RAM_BYTES-1];

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire addr_ok = HADDR[31:8] == 24'h0;
	wire [7:0] ra = HADDR[7:0];
	wire bus_take = CE & HSEL & HTRANS[1] & HREADY;
	wire wr_on = CE & wr_pend;
	wire [7:0] wd = HWDATA[7:0];
	wire cpm_mode_t wr_mode = cpm_mode_t'(HWDATA[1:0]);
	wire w_div = wr_on & (wr_addr == A_CLKDIV);
	wire w_aux = wr_on & (wr_addr == A_AUX1);
	wire w_pwr = wr_on & (wr_addr == A_PWR);
	wire w_rc = wr_on & (wr_addr == A_RCAUSE);
	wire w_p0m1 = wr_on & (wr_addr == A_P0M1);
	wire w_p0m2 = wr_on & (wr_addr == A_P0M2);
	wire w_p1m1 = wr_on & (wr_addr == A_P1M1);
	wire w_p1m2 = wr_on & (wr_addr == A_P1M2);
	wire w_p3m1 = wr_on & (wr_addr == A_P3M1);
	wire w_p3m2 = wr_on & (wr_addr == A_P3M2);
	wire w_iplo = wr_on & (wr_addr == A_IPLO);
	wire w_iphi = wr_on & (wr_addr == A_IPHI);

	// Stall the bus while frozen so no transfer is lost
	assign HREADYOUT = CE;
	assign HRESP = 1'b0;

	always_comb begin
		rd_mux = 32'h0;
		if (!addr_ok) begin
			rd_mux = 32'h0;
		end else if (ra == A_CLKDIV) begin
			rd_mux = {24'h0, clkdiv};
		end else if (ra == A_AUX1) begin
			rd_mux = {24'h0, lpsel, 7'h0};
		end else if (ra == A_PWR) begin
			rd_mux = {22'h0, 1'b0, cmp_pd, rtc_en, 1'b0, brownout_enable_cfg, boi, 2'h0, mode};
		end else if (ra == A_RCAUSE) begin
			rd_mux = {26'h0, rcause};
		end else if (ra == A_P0M1) begin
			rd_mux = {24'h0, p0.m1};
		end else if (ra == A_P0M2) begin
			rd_mux = {24'h0, p0.m2};
		end else if (ra == A_P1M1) begin
			rd_mux = {24'h0, p1.m1};
		end else if (ra == A_P1M2) begin
			rd_mux = {24'h0, p1.m2};
		end else if (ra == A_P3M1) begin
			rd_mux = {24'h0, p3.m1};
		end else if (ra == A_P3M2) begin
			rd_mux = {24'h0, p3.m2};
		end else if (ra == A_IPLO) begin
			rd_mux = {24'h0, ip_lo};
		end else if (ra == A_IPHI) begin
			rd_mux = {24'h0, ip_hi};
		end else if (ra == A_STAT) begin
			rd_mux = {21'h0, USABLE_PINS, 3'h0, wake_rst, state};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			wr_pend <= 1'b0;
			wr_addr <= A_NONE;
			HRDATA <= 32'h0;
		end else if (CE) begin
			wr_pend <= bus_take & HWRITE;
			if (bus_take)
				wr_addr <= addr_ok ? ra : A_NONE;
			if (bus_take & !HWRITE)
				HRDATA <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// Reset sources and cause flags
	// ------------------------------------------------------------
	wire sw_rst = w_pwr & HWDATA[PWR_SWRST];
	wire st_pd = state == ST_PD;
	wire tpd_now = st_pd & (mode == MD_TPD);
	assign BOD_ON = brownout_enable_cfg & !tpd_now;
	wire bo_hit = BO_DET & BOD_ON;
	wire bo_rst = bo_hit & !boi;
	wire any_rst = EXT_RST_REQ | WDT_RST_REQ | BRK_RST_REQ | sw_rst | bo_rst;
	wire [5:0] rc_set = {bo_rst, 1'b0, BRK_RST_REQ, WDT_RST_REQ, sw_rst, EXT_RST_REQ};
	wire [5:0] rc_keep = w_rc ? wd[5:0] : 6'h3f;
	// A cause arriving with a clearing write still lands
	wire [5:0] next_rcause = (rcause & rc_keep) | rc_set;

	always_ff @(posedge REF_CLK) begin
		if (!RSTN)
			rcause <= RCAUSE_RST;
		else if (CE)
			rcause <= next_rcause;
	end

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	wire xtal = CLK_SRC == CS_XTAL;
	wire [11:0] wake_load = xtal ? WAKE_LOAD : WAKE_SHORT;
	wire enter = w_pwr & (state == ST_RUN) & (wr_mode != MD_RUN);

	always_comb begin
		next_state = state;
		next_wake_cnt = wake_cnt;
		if (any_rst) begin
			next_state = ST_WAKE;
			next_wake_cnt = wake_load;
		end else begin
			case (state)
				ST_WAKE: begin
					if (wake_cnt == 12'h0)
						next_state = ST_RUN;
					else
						next_wake_cnt = wake_cnt - 12'h1;
				end
				ST_RUN: begin
					if (enter)
						next_state = (wr_mode == MD_IDLE) ? ST_IDLE : ST_PD;
				end
				ST_IDLE: begin
					if (IRQ_WAKE)
						next_state = ST_RUN;
				end
				ST_PD: begin
					if (PD_WAKE) begin
						next_state = ST_WAKE;
						next_wake_cnt = wake_load;
					end
				end
				default: begin
					next_state = ST_WAKE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			state <= ST_WAKE;
			wake_cnt <= WAKE_LOAD;
			wake_rst <= 1'b1;
		end else if (CE) begin
			state <= next_state;
			wake_cnt <= next_wake_cnt;
			if (any_rst)
				wake_rst <= 1'b1;
			else if (st_pd)
				wake_rst <= 1'b0;
		end
	end

	assign CORE_RST = (state == ST_WAKE) & wake_rst;
	assign PERIPH_RUN = (state == ST_RUN) | (state == ST_IDLE);
	assign OSC_ON = !st_pd;
	// RC kept only when it clocks the running timer
	assign RC_OSC_ON = (CLK_SRC == CS_RC) & (!st_pd | rtc_en);
	assign CMP_ON = !cmp_pd & !tpd_now;
	assign LP_SEL = lpsel;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RSTN || (CE && any_rst)) begin
			clkdiv <= DIV_RST;
			lpsel <= 1'b0;
			mode <= MD_RUN;
			boi <= 1'b0;
			brownout_enable_cfg <= 1'b1;
			rtc_en <= 1'b0;
			cmp_pd <= 1'b0;
		end else if (CE) begin
			if (w_div)
				clkdiv <= wd;
			if (w_aux)
				lpsel <= wd[AUX_LPSEL];
			if (enter)
				mode <= wr_mode;
			else if (next_state == ST_RUN || next_state == ST_WAKE)
				mode <= MD_RUN;
			if (w_pwr) begin
				boi <= HWDATA[PWR_BOI];
				brownout_enable_cfg <= HWDATA[PWR_BOE];
				rtc_en <= HWDATA[PWR_RTCEN];
				cmp_pd <= HWDATA[PWR_CMPPD];
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN || (CE && any_rst)) begin
			p0 <= '{m1: PM1_RST, m2: PM2_RST};
			p1 <= '{m1: PM1_RST, m2: PM2_RST};
			p3 <= '{m1: PM1_RST, m2: PM2_RST};
		end else if (CE) begin
			if (w_p0m1)
				p0.m1 <= wd;
			if (w_p0m2)
				p0.m2 <= wd;
			if (w_p1m1)
				p1.m1 <= wd | SHR_MASK;
			if (w_p1m2)
				p1.m2 <= wd & ~SHR_MASK;
			if (w_p3m1)
				p3.m1 <= wd;
			if (w_p3m2)
				p3.m2 <= wd;
		end
	end

	assign PORT0_CFG = p0;
	assign PORT1_CFG = p1;
	assign PORT3_CFG = p3;

	// ------------------------------------------------------------
	// CPU clock divider
	// ------------------------------------------------------------
	// Compare with >= so a shrinking ratio wraps at once, never stalls
	wire [8:0] div_top = {clkdiv, 1'b0} - 9'h1;
	wire div_wrap = (clkdiv == 8'h0) | (div_cnt >= div_top);

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			div_cnt <= 9'h0;
			CPU_TICK <= 1'b0;
		end else if (CE) begin
			if (state != ST_RUN || div_wrap)
				div_cnt <= 9'h0;
			else
				div_cnt <= div_cnt + 9'h1;
			CPU_TICK <= (state == ST_RUN) & div_wrap;
		end
	end

	// ------------------------------------------------------------
	// Interrupt arbitration, brownout irq, pin count
	// ------------------------------------------------------------
	always_comb begin
		arb_ok = 1'b0;
		arb_id = 3'h0;
		arb_lvl = 2'h0;
		lvl = 2'h0;
		for (int i = 0; i < IRQ_SRCS; i++) begin
			lvl = {ip_hi[i], ip_lo[i]};
			if (IRQ_REQ[i] && (!arb_ok || lvl > arb_lvl)) begin
				arb_ok = 1'b1;
				arb_id = 3'(i);
				arb_lvl = lvl;
			end
		end
	end

	wire [2:0] clk_pins = xtal ? 3'h2 : ((CLK_SRC == CS_EXT) ? 3'h1 : 3'h0);
	wire [2:0] next_pins = PINS_MAX - clk_pins - {2'h0, RST_PIN_EN};

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			ip_lo <= 8'h00;
			ip_hi <= 8'h00;
			IRQ_VALID <= 1'b0;
			IRQ_ID <= 3'h0;
			IRQ_LEVEL <= 2'h0;
			BO_IRQ <= 1'b0;
			USABLE_PINS <= 3'h0;
		end else if (CE) begin
			if (w_iplo)
				ip_lo <= wd;
			if (w_iphi)
				ip_hi <= wd;
			IRQ_VALID <= arb_ok;
			IRQ_ID <= arb_id;
			IRQ_LEVEL <= arb_lvl;
			BO_IRQ <= bo_hit & boi;
			USABLE_PINS <= next_pins;
		end
	end

	// ------------------------------------------------------------
	// Memory spaces
	// ------------------------------------------------------------
	wire dm_hit = DM_ADDR < RAM_TOP;
	assign SFR_SEL = !dm_hit & !DM_IND;
	assign CODE_ONCHIP = CODE_ADDR < CODE_TOP;

	always_ff @(posedge REF_CLK) begin
		if (CE && DM_WR && dm_hit)
			dram[DM_ADDR[6:0]] <= DM_WDATA;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN)
			DM_RDATA <= 8'h00;
		else if (CE)
			DM_RDATA <= dm_hit ? dram[DM_ADDR[6:0]] : 8'h00;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_wake_load;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && any_rst && xtal) |=> (state == ST_WAKE && wake_cnt == WAKE_LOAD);
	endproperty
	a_wake_load: assert property (p_wake_load)
		else $error("crystal wake delay not loaded");

	property p_wake_end;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && state == ST_WAKE && wake_cnt == 12'h0 && !any_rst) |=> CPU_TICK == 1'b0
			##0 state == ST_RUN;
	endproperty
	a_wake_end: assert property (p_wake_end)
		else $error("wake delay did not release core");

	property p_div_wrap;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && state == ST_RUN && clkdiv != 8'h0 && div_wrap) |=> (CPU_TICK && div_cnt == 9'h0);
	endproperty
	a_div_wrap: assert property (p_div_wrap)
		else $error("divider did not wrap at 2N");

	property p_div_pass;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && state == ST_RUN && clkdiv == 8'h0)[*2] |=> CPU_TICK;
	endproperty
	a_div_pass: assert property (p_div_pass)
		else $error("undivided clock missed a tick");

	property p_lp_clear;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && any_rst) |=> !LP_SEL;
	endproperty
	a_lp_clear: assert property (p_lp_clear)
		else $error("low-power select survived reset");

	property p_por_flags;
		@(posedge REF_CLK)
		!RSTN |=> rcause == 6'h30;
	endproperty
	a_por_flags: assert property (p_por_flags)
		else $error("power-on cause flags wrong");

	property p_flag_clear;
		@(posedge REF_CLK) disable iff (!RSTN)
		(w_rc && !HWDATA[RC_EXT] && !EXT_RST_REQ) |=> !rcause[RC_EXT];
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("zero write did not clear flag");

	property p_ram;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && DM_WR && dm_hit) ##1 (CE && !DM_WR && DM_ADDR == $past(DM_ADDR))
			|=> DM_RDATA == $past(DM_WDATA, 2);
	endproperty
	a_ram: assert property (p_ram)
		else $error("data RAM readback mismatch");

	property p_idle_exit;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && state == ST_IDLE && IRQ_WAKE && !any_rst) |=> (state == ST_RUN && PERIPH_RUN);
	endproperty
	a_idle_exit: assert property (p_idle_exit)
		else $error("idle not left on interrupt");

	property p_pd_exit;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && st_pd && PD_WAKE && !any_rst) |=> (state == ST_WAKE && !CORE_RST && OSC_ON);
	endproperty
	a_pd_exit: assert property (p_pd_exit)
		else $error("power-down exit skipped wake delay");

	property p_bo_reset;
		@(posedge REF_CLK) disable iff (!RSTN)
		(CE && BO_DET && brownout_enable_cfg && !boi && !st_pd) |=> (CORE_RST && rcause[RC_BOF]);
	endproperty
	a_bo_reset: assert property (p_bo_reset)
		else $error("brownout did not reset core");

	property p_tpd_off;
		@(posedge REF_CLK) disable iff (!RSTN)
		tpd_now |-> (!BOD_ON && !CMP_ON && !OSC_ON);
	endproperty
	a_tpd_off: assert property (p_tpd_off)
		else $error("total power-down left blocks on");

	property p_shr_pin;
		@(posedge REF_CLK) disable iff (!RSTN)
		w_p1m1 |=> (PORT1_CFG.m1[5] && !PORT1_CFG.m2[5]);
	endproperty
	a_shr_pin: assert property (p_shr_pin)
		else $error("shared reset pin not forced input-only");
endmodule // cpm_top
`default_nettype wire

// ==== test/cpm_core_model.sv ====
// Processor core stand-in that counts executed CPU clock cycles
`timescale 1ns/1ns
`default_nettype none
module cpm_core_model
	import cpm_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Power-on reset
	input wire logic ce, // Clock enable
	input wire logic cpu_tick, // CPU clock enable
	input wire logic core_rst, // Core held in reset
	output logic [15:0] exec_count // Executed cycles
);
	// ------------------------------------------------------------
	// Execution
	// ------------------------------------------------------------
	// A core in reset executes nothing, ticks or not
	always_ff @(posedge clk) begin
		if (!rst_n)
			exec_count <= 16'h0000;
		else if (ce && cpu_tick && !core_rst)
			exec_count <= exec_count + 16'h0001;
	end
endmodule // cpm_core_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the clock and power management block
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import cpm_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rpe = 1'b0, ce = 1'b1;
	logic bo_det = 1'b0, irq_wake = 1'b0, pd_wake = 1'b0, dm_ind = 1'b0, dm_wr = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] rq = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, d, ex;
	logic [7:0] irq_req = 8'h00, dm_addr = 8'h00, dm_wdata = 8'h00, dm_rdata;
	logic [15:0] code_addr = 16'h0000, c0, exec_count;
	cpm_clksrc_t clk_src = CS_XTAL;
	logic hready, hresp, cpu_tick, core_rst, periph_run, osc_on, rc_on, bod_on, cmp_on;
	logic bo_irq, lp_sel, irq_valid, code_onchip, sfr_sel;
	logic [31:0] hrdata;
	logic [2:0] irq_id, pins_out;
	logic [1:0] irq_level;
	cpm_pcfg_t p0_cfg, p1_cfg, p3_cfg;
	int seed = 51, i, n, bad_count = 0, check_count = 0;

	cpm_top dut (.REF_CLK(clk), .RSTN(rstn), .CE(ce), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .CLK_SRC(clk_src),
		.RST_PIN_EN(rpe), .EXT_RST_REQ(rq[0]), .WDT_RST_REQ(rq[1]), .BRK_RST_REQ(rq[2]),
		.BO_DET(bo_det), .IRQ_WAKE(irq_wake), .PD_WAKE(pd_wake), .IRQ_REQ(irq_req),
		.DM_ADDR(dm_addr), .DM_IND(dm_ind), .DM_WR(dm_wr), .DM_WDATA(dm_wdata),
		.DM_RDATA(dm_rdata), .SFR_SEL(sfr_sel), .CODE_ADDR(code_addr),
		.CODE_ONCHIP(code_onchip), .CPU_TICK(cpu_tick), .CORE_RST(core_rst),
		.PERIPH_RUN(periph_run), .OSC_ON(osc_on), .RC_OSC_ON(rc_on), .BOD_ON(bod_on),
		.CMP_ON(cmp_on), .BO_IRQ(bo_irq), .LP_SEL(lp_sel), .PORT0_CFG(p0_cfg),
		.PORT1_CFG(p1_cfg), .PORT3_CFG(p3_cfg), .IRQ_VALID(irq_valid), .IRQ_ID(irq_id),
		.IRQ_LEVEL(irq_level), .USABLE_PINS(pins_out));
	cpm_core_model core (.clk(clk), .rst_n(rstn), .ce(ce), .cpu_tick(cpu_tick),
		.core_rst(core_rst), .exec_count(exec_count));

	// ------------------------------------------------------------
	// Tasks and expectations
	// ------------------------------------------------------------
	function automatic logic [2:0] pins(input logic [1:0] s, input logic e);
		return 3'h6 - ((s == 2'h3) ? 3'h2 : (s == 2'h2) ? 3'h1 : 3'h0) - {2'h0, e};
	endfunction
	function automatic int ticks(input int nd, input int len);
		return (nd == 0) ? len : len / (2 * nd);
	endfunction
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic give_up();
		bad_count++;
		complete_run();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic st(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (k >= 50)
			give_up();
	endtask
	// Read data is taken at the edge that ends the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wt(input logic [7:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		// An error response shows up as a stray top bit
		chk(rd | {hresp, 31'h0}, exp);
	endtask
	// Waits for the core release, or for run after power-down
	task automatic wake_len(input logic pd, output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while ((pd ? periph_run : !core_rst) !== 1'b1 && k < 5000);
		if (k >= 5000)
			give_up();
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial forever #10 clk = ~clk;
	initial begin
		#2_000_000;
		give_up();
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		wake_len(1'b0, n);
		chk(n, 992 + 60 * 1000 / 20);
		rc(A_RCAUSE, 32'h30);
		rc(A_AUX1, 32'h0);
		for (i = 0; i < 6; i++)
			rc(A_P0M1 + 8'(4 * i), i[0] ? 32'h0 : 32'hff);
		chk(p3_cfg, 16'hff00);
		// Run state, woken by reset, four pins with a crystal
		rc(A_STAT, 32'h412);
		wt(A_NONE, 32'hffffffff);
		rc(A_NONE, 32'h0);
		wt(A_RCAUSE, 32'h20);
		rc(A_RCAUSE, 32'h20);
		for (i = 0; i < 4; i++) begin
			d = (i == 0) ? 32'h0 : (i == 1) ? 32'h7f : 32'($random(seed)) & 32'h7f;
			@(posedge clk);
			dm_addr <= d[7:0];
			dm_wdata <= d[7:0] ^ 8'h5a;
			dm_wr <= 1'b1;
			dm_ind <= i[0];
			@(posedge clk);
			dm_wr <= 1'b0;
			st(1);
			chk(dm_rdata, d[7:0] ^ 8'h5a);
			chk(sfr_sel, 1'b0);
		end
		@(posedge clk);
		dm_addr <= 8'h80;
		dm_ind <= 1'b0;
		code_addr <= 16'h03ff;
		st(1);
		chk({sfr_sel, code_onchip, dm_rdata}, 10'h300);
		dm_ind <= 1'b1;
		code_addr <= 16'h0400;
		st(1);
		chk({sfr_sel, code_onchip}, 2'h0);
		for (i = 0; i < 4; i++) begin
			d = (i == 0) ? 32'h0 : (i == 1) ? 32'hff : 32'($random(seed)) & 32'hff;
			wt(A_CLKDIV, d);
			n = (d == 0) ? 16 : 32 * int'(d);
			st(520);
			c0 = exec_count;
			st(n);
			chk(exec_count - c0, 16'(ticks(int'(d), n)));
		end
		// Frozen enable: bus stalls, strap change and core ticks wait
		@(posedge clk);
		ce <= 1'b0;
		rpe <= 1'b1;
		st(1);
		c0 = exec_count;
		st(4);
		chk({hready, pins_out, exec_count}, {1'b0, 3'h4, c0});
		ce <= 1'b1;
		st(2);
		chk(pins_out, 3'h3);
		rpe <= 1'b0;
		wt(A_P1M1, 32'h0);
		wt(A_P1M2, 32'hff);
		rc(A_P1M1, 32'h20);
		rc(A_P1M2, 32'hdf);
		chk(p1_cfg, 16'h20df);
		d = 32'($random(seed)) & 32'hff;
		wt(A_P0M1, d);
		rc(A_P0M1, d);
		chk(p0_cfg.m1, d);
		wt(A_IPLO, 32'h04);
		wt(A_IPHI, 32'h06);
		@(posedge clk);
		irq_req <= 8'h0b;
		st(2);
		chk({irq_valid, irq_id, irq_level}, 6'h26);
		irq_req <= 8'hff;
		st(2);
		chk({irq_valid, irq_id, irq_level}, 6'h2b);
		irq_req <= 8'h09;
		st(2);
		chk({irq_valid, irq_id, irq_level}, 6'h20);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			clk_src <= cpm_clksrc_t'(i[1:0]);
			rpe <= i[2];
			st(3);
			chk(pins_out, pins(i[1:0], i[2]));
		end
		@(posedge clk);
		clk_src <= CS_RC;
		rpe <= 1'b0;
		wt(A_CLKDIV, 32'h4);
		// Low-power select only once the CPU clock is slow enough
		wt(A_AUX1, 32'h80);
		st(1);
		chk(lp_sel, 1'b1);
		wt(A_PWR, 32'h220);
		st(4);
		chk(lp_sel, 1'b0);
		rc(A_AUX1, 32'h0);
		rc(A_RCAUSE, 32'h22);
		ex = 32'h22;
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			rq <= 3'(1 << i);
			@(posedge clk);
			rq <= 3'h0;
			ex = ex | ((i == 0) ? 32'h1 : 32'h4 << (i - 1));
			rc(A_RCAUSE, ex);
		end
		wt(A_RCAUSE, 32'h0);
		rc(A_RCAUSE, 32'h0);
		wt(A_PWR, 32'h30);
		@(posedge clk);
		bo_det <= 1'b1;
		st(2);
		chk({bo_irq, core_rst}, 2'h2);
		bo_det <= 1'b0;
		wt(A_PWR, 32'h0);
		@(posedge clk);
		bo_det <= 1'b1;
		st(3);
		chk({bod_on, bo_irq, core_rst}, 3'h0);
		bo_det <= 1'b0;
		rc(A_RCAUSE, 32'h0);
		wt(A_PWR, 32'h20);
		@(posedge clk);
		bo_det <= 1'b1;
		@(posedge clk);
		bo_det <= 1'b0;
		rc(A_RCAUSE, 32'h20);
		wt(A_PWR, 32'h21);
		st(3);
		c0 = exec_count;
		chk(periph_run, 1'b1);
		st(20);
		chk(exec_count, c0);
		irq_wake <= 1'b1;
		@(posedge clk);
		irq_wake <= 1'b0;
		rc(A_PWR, 32'h20);
		wt(A_PWR, 32'ha2);
		st(2);
		chk({osc_on, bod_on, cmp_on, rc_on}, 4'h7);
		pd_wake <= 1'b1;
		@(posedge clk);
		pd_wake <= 1'b0;
		st(3);
		chk({osc_on, core_rst}, 2'h2);
		wt(A_PWR, 32'h23);
		st(2);
		chk({osc_on, bod_on, cmp_on, rc_on}, 4'h0);
		// Crystal strap: leaving total power-down waits the full delay
		@(posedge clk);
		clk_src <= CS_XTAL;
		pd_wake <= 1'b1;
		@(posedge clk);
		pd_wake <= 1'b0;
		wake_len(1'b1, n);
		chk(n, 992 + 60 * 1000 / 20);
		chk(core_rst, 1'b0);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
